// ==== ovr_fault_resp.sv ====
// Function
// - set ov status, vout word, vout ov bits
// - alert on ov fault unless masked
// - 0x00: crowbar while output above limit
// - 0x80: disable at once, no retry
// - 0xB8: disable then retry without limit
// - 0x4n: latch off after n*10us persistence
// - 0x78+n: shut down after n*10us, retry
// - bad value: drop write, flag cml
// - field 01: run delay, then retry field
// - field 10: disable now, then retry field
// - field 11: unsupported, cml fault
// - retry 000 none, 111 unlimited spaced
// - delay field counts 10us steps
// - status sticky until clear, off-on, power
// - retry interval from millisecond setting
`include "ovr_consts.svh"
`default_nettype none
module ovr_fault_resp
	import ovr_pkg::*;
#(
	parameter int MS_CYC = `OVR_MS_CYC
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cfg_wr_en,
	input wire logic [7:0] cfg_wr_data,
	output logic [7:0] cfg_rd_data,
	input wire logic ov_comp,
	input wire logic run_pin,
	input wire logic op_on,
	input wire logic clear_faults,
	input wire logic reset_cmd,
	input wire logic other_fault_off,
	input wire logic alert_mask,
	input wire logic [16:0] restart_interval_setting,
	output logic out_enable,
	output logic crowbar_only_action,
	output logic status_byte_ov,
	output logic status_word_vout,
	output logic status_vout_ov,
	output logic cml_fault,
	output logic alert_n_o,
	output logic alert_n_oe,
	output logic [1:0] resp_state
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0] cfg_reg; // response setting
	ovr_state_t state_reg; // channel state
	ovr_state_t state_next;
	logic [2:0] pcnt_reg; // persistence steps seen
	logic [16:0] ms_reg; // ms since detection
	logic on_reg; // last pin-and-command on level
	logic pull_reg; // crowbar drive
	logic ov_reg; // sticky ov flag
	logic cml_reg; // sticky cml flag
	logic cfg_ok; // written value accepted
	logic chan_on; // pin and command agree on
	logic on_edge; // off-then-on seen
	logic detect; // fault seen while running
	logic act; // take the shutdown action
	logic [1:0] resp;
	logic [2:0] retry;
	logic [2:0] dly;
	logic [16:0] intv; // clamped retry interval
	ovr_tick_if step_if ();
	ovr_tick_if ms_if ();

	assign resp = cfg_reg[`OVR_RESP_MSB:`OVR_RESP_LSB];
	assign retry = cfg_reg[`OVR_RETRY_MSB:`OVR_RETRY_LSB];
	assign dly = cfg_reg[`OVR_DELAY_MSB:`OVR_DELAY_LSB];
	assign chan_on = run_pin && op_on;
	assign on_edge = chan_on && !on_reg;

	// ----------------------------------------
	// timebases
	// ----------------------------------------
	// 10us step for persistence, restarted at each new window
	ovr_tick_gen #(.DIV(`OVR_STEP_CYC)) u_step
	(
		.clk_sys(clk_sys),
		.rstn(rstn),
		.tk(step_if.gen)
	);
	// 1ms step for retry spacing, phased from detection
	ovr_tick_gen #(.DIV(MS_CYC)) u_ms
	(
		.clk_sys(clk_sys),
		.rstn(rstn),
		.tk(ms_if.gen)
	);
	assign step_if.sync_clr = detect;
	assign ms_if.sync_clr = detect;

	// ----------------------------------------
	// setting register
	// ----------------------------------------
	// only the documented encodings are accepted
	always_comb
	begin
		cfg_ok = 1'b0;
		if (cfg_wr_data == `OVR_CODE_CROWBAR || cfg_wr_data == `OVR_CODE_LATCH ||
			cfg_wr_data == `OVR_CODE_RETRY)
			cfg_ok = 1'b1;
		else if (cfg_wr_data[7:3] == `OVR_CODE_DLY_LATCH ||
			cfg_wr_data[7:3] == `OVR_CODE_DLY_RETRY)
			cfg_ok = 1'b1;
	end

	// whole byte per write; a rejected byte leaves the old value
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			cfg_reg <= `OVR_CFG_RESET;
		else if (cfg_wr_en && cfg_ok)
			cfg_reg <= cfg_wr_data;
	end
	assign cfg_rd_data = cfg_reg;

	// cml flag, set wins over clear
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			cml_reg <= 1'b0;
		else if (cfg_wr_en && !cfg_ok)
			cml_reg <= 1'b1;
		else if (clear_faults || reset_cmd)
			cml_reg <= 1'b0;
	end

	// ----------------------------------------
	// response sequencing
	// ----------------------------------------
	// crowbar mode never shuts down, so it never enters the sequence
	assign detect = (state_reg == ovr_st_run) && chan_on && ov_comp &&
		(resp != `OVR_RESP_CROWBAR);
	// delayed mode waits n steps; immediate or n = 0 acts now
	assign act = (detect && (resp == `OVR_RESP_IMMEDIATE || dly == 3'h0)) ||
		(state_reg == ovr_st_persist && ov_comp && step_if.tick &&
		pcnt_reg + 3'h1 == dly);
	// interval below the legal floor is raised to it
	assign intv = (restart_interval_setting < `OVR_RETRY_MIN_MS) ? `OVR_RETRY_MIN_MS :
		restart_interval_setting;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ovr_st_run:
			begin
				if (detect && resp == `OVR_RESP_DELAYED && dly != 3'h0)
					state_next = ovr_st_persist;
			end
			ovr_st_persist:
			begin
				if (!ov_comp)
					state_next = ovr_st_run;
			end
			ovr_st_retry:
			begin
				if (other_fault_off)
					state_next = ovr_st_latched;
				else if (ms_reg >= intv)
					state_next = ovr_st_run;
			end
			ovr_st_latched:
			begin
				state_next = ovr_st_latched;
			end
		endcase
		if (act)
			state_next = (retry == `OVR_RETRY_FOREVER) ? ovr_st_retry :
				ovr_st_latched;
		// off-then-on, reset or commanded off ends any sequence
		if (!chan_on || reset_cmd)
			state_next = ovr_st_run;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			state_reg <= ovr_st_run;
		else
			state_reg <= state_next;
	end

	// persistence step count, cleared at each new window
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			pcnt_reg <= 3'h0;
		else if (detect)
			pcnt_reg <= 3'h0;
		else if (state_reg == ovr_st_persist && step_if.tick)
			pcnt_reg <= pcnt_reg + 3'h1;
	end

	// ms count from detection; saturates at the legal ceiling
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			ms_reg <= 17'h0;
		else if (detect)
			ms_reg <= 17'h0;
		else if (ms_if.tick && ms_reg != `OVR_RETRY_MAX_MS)
			ms_reg <= ms_reg + 17'h1;
	end

	// last on level, for the off-then-on edge
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		// idles as on, so leaving reset with the channel on is no off-then-on
		if (!rstn)
			on_reg <= 1'b1;
		else
			on_reg <= chan_on;
	end

	// ----------------------------------------
	// power stage drive
	// ----------------------------------------
	// low side on only while above the limit in crowbar mode; out_enable is left on
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			pull_reg <= 1'b0;
		else
			pull_reg <= ov_comp && resp == `OVR_RESP_CROWBAR;
	end
	assign crowbar_only_action = pull_reg;
	// output regulates in run and while persistence is still open
	assign out_enable = chan_on && (state_reg == ovr_st_run || state_reg == ovr_st_persist);
	assign resp_state = state_reg;

	// ----------------------------------------
	// status and alert
	// ----------------------------------------
	// sticky ov flag; a new fault beats a same-cycle clear
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			ov_reg <= 1'b0;
		else if (ov_comp)
			ov_reg <= 1'b1;
		else if (clear_faults || on_edge || reset_cmd)
			ov_reg <= 1'b0;
	end
	assign status_byte_ov = ov_reg;
	assign status_word_vout = ov_reg;
	assign status_vout_ov = ov_reg;
	assign cml_fault = cml_reg;
	// open-drain alert: pin is only ever pulled low
	assign alert_n_o = 1'b0;
	assign alert_n_oe = (ov_reg && !alert_mask) || cml_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	status_set_a: assert property (ov_comp |=> status_vout_ov && status_byte_ov)
		else $error("ov status not set");
	alert_drive_a: assert property (ov_comp && !alert_mask |=> alert_n_oe)
		else $error("alert not raised");
	crowbar_follow_a: assert property (resp == 2'h0 && !cfg_wr_en |=>
		crowbar_only_action == $past(ov_comp))
		else $error("crowbar not tracking comparator");
	latch_off_a: assert property (cfg_reg == 8'h80 && detect |=> !out_enable)
		else $error("no immediate shutdown");
	retry_enter_a: assert property (act && retry == 3'h7 && chan_on && !reset_cmd
		|=> state_reg == ovr_st_retry)
		else $error("retry not entered");
	latch_hold_a: assert property (state_reg == ovr_st_latched && chan_on && !reset_cmd
		|=> state_reg == ovr_st_latched)
		else $error("latched state left");
	bad_write_a: assert property (cfg_wr_en && !cfg_ok |=> cml_fault && $stable(cfg_reg))
		else $error("bad write accepted");
	persist_reset_a: assert property (state_reg == ovr_st_persist && !ov_comp && chan_on
		|=> state_reg == ovr_st_run)
		else $error("persistence not restarted");
	sticky_ov_a: assert property (ov_reg && !clear_faults && !on_edge && !reset_cmd
		|=> ov_reg)
		else $error("ov flag dropped");
	persist_time_a: assert property (state_reg == ovr_st_persist && step_if.tick
		|=> pcnt_reg == $past(pcnt_reg) + 3'h1 || state_reg != ovr_st_persist)
		else $error("step count off");
endmodule
`default_nettype wire

// ==== ovr_consts.svh ====
`ifndef OVR_CONSTS_SVH
`define OVR_CONSTS_SVH
// ----------------------------------------
// response setting layout
// ----------------------------------------
`define OVR_CFG_RESET 8'hB8
`define OVR_RESP_MSB 7
`define OVR_RESP_LSB 6
`define OVR_RETRY_MSB 5
`define OVR_RETRY_LSB 3
`define OVR_DELAY_MSB 2
`define OVR_DELAY_LSB 0
`define OVR_RESP_CROWBAR 2'h0
`define OVR_RESP_DELAYED 2'h1
`define OVR_RESP_IMMEDIATE 2'h2
`define OVR_RETRY_NONE 3'h0
`define OVR_RETRY_FOREVER 3'h7
// accepted encodings
`define OVR_CODE_CROWBAR 8'h00
`define OVR_CODE_LATCH 8'h80
`define OVR_CODE_RETRY 8'hB8
`define OVR_CODE_DLY_LATCH 5'h08
`define OVR_CODE_DLY_RETRY 5'h0F
// ----------------------------------------
// timing
// ----------------------------------------
`define OVR_CLK_MHZ 25
`define OVR_STEP_NS 10000
`define OVR_STEP_CYC (`OVR_STEP_NS * `OVR_CLK_MHZ / 1000)
`define OVR_MS_NS 1000000
`define OVR_MS_CYC (`OVR_MS_NS * `OVR_CLK_MHZ / 1000)
`define OVR_RETRY_MIN_MS 17'h00078
`define OVR_RETRY_MAX_MS 17'h147A8
`endif

// ==== ovr_pkg.sv ====
`default_nettype none
package ovr_pkg;
	// channel response state
	typedef enum logic [1:0]
	{
		ovr_st_run,
		ovr_st_persist,
		ovr_st_retry,
		ovr_st_latched
	} ovr_state_t;
endpackage
`default_nettype wire

// ==== ovr_tick_if.sv ====
`default_nettype none
interface ovr_tick_if;
	logic tick; // one-cycle enable pulse
	logic sync_clr; // restart the divider phase
	modport gen (output tick, input sync_clr);
	modport sink (input tick, output sync_clr);
endinterface
`default_nettype wire

// ==== ovr_tick_gen.sv ====
`include "ovr_consts.svh"
`default_nettype none
module ovr_tick_gen
	import ovr_pkg::*;
#(
	parameter int DIV = `OVR_STEP_CYC
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	ovr_tick_if.gen tk
);
	localparam int W = $clog2(DIV + 1);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	logic [W-1:0] cnt_reg; // divider phase
	// ----------------------------------------
	// divider
	// ----------------------------------------
	// sync clear lets a fresh window start a full period long
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			cnt_reg <= '0;
		else if (tk.sync_clr || cnt_reg == LAST)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + 1'b1;
	end
	assign tk.tick = (cnt_reg == LAST) && !tk.sync_clr;
endmodule
`default_nettype wire

// ==== ovr_host_model.sv ====
`default_nettype none
// ----------------------------------------
// far side: bus host and power stage
// ----------------------------------------
module ovr_host_model
(
	input wire logic clk_sys,
	output logic cfg_wr_en,
	output logic [7:0] cfg_wr_data,
	output logic ov_comp
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels at time zero
	initial
	begin
		cfg_wr_en = 1'b0;
		cfg_wr_data = 8'h5A;
		ov_comp = 1'b0;
	end
	// one byte per strobe; data inverted once released, so stale bytes change but may still look valid
	task automatic wr(input logic [7:0] b);
		@(negedge clk_sys);
		cfg_wr_en = 1'b1;
		cfg_wr_data = b;
		@(negedge clk_sys);
		cfg_wr_en = 1'b0;
		cfg_wr_data = ~b;
	endtask
	// comparator level from the output stage
	task automatic ov(input logic lvl);
		@(negedge clk_sys);
		ov_comp = lvl;
	endtask
endmodule
`default_nettype wire

// ==== ovr_fault_resp_test.sv ====
`default_nettype none
module ovr_fault_resp_test
	import ovr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals and scoreboard
	// ----------------------------------------
	typedef struct {int kind; logic [7:0] val;} ovr_note_t;
	ovr_note_t note_q[$]; // expected results, oldest first
	logic clk_sys, rstn, cfg_wr_en, ov_comp, run_pin, op_on, clear_faults, reset_cmd;
	logic other_fault_off, alert_mask, out_enable, crowbar_only_action, status_byte_ov;
	logic status_word_vout, status_vout_ov, cml_fault, alert_n_oe, alert_n_o;
	logic [7:0] codes [5]; // accepted setting codes, in write order
	logic [7:0] cfg_wr_data, cfg_rd_data;
	logic [16:0] restart_interval_setting;
	logic [1:0] resp_state;
	int err_count, n_tests, n;
	int iv; // expected retry interval in ms, floor applied
	// short millisecond step keeps the run small
	ovr_fault_resp #(.MS_CYC(10)) ovr_fault_resp_i (.clk_sys(clk_sys), .rstn(rstn),
		.cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
		.ov_comp(ov_comp), .run_pin(run_pin), .op_on(op_on), .clear_faults(clear_faults),
		.reset_cmd(reset_cmd), .other_fault_off(other_fault_off), .alert_mask(alert_mask),
		.restart_interval_setting(restart_interval_setting), .out_enable(out_enable),
		.crowbar_only_action(crowbar_only_action), .status_byte_ov(status_byte_ov),
		.status_word_vout(status_word_vout), .status_vout_ov(status_vout_ov),
		.cml_fault(cml_fault), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
		.resp_state(resp_state));
	ovr_host_model ovr_host_model_i (.clk_sys(clk_sys), .cfg_wr_en(cfg_wr_en),
		.cfg_wr_data(cfg_wr_data), .ov_comp(ov_comp));
	// 40 ns clock
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// kind 0 setting, 1 flags, 2 state/enable/crowbar
	task automatic note(input int k, input logic [7:0] v);
		note_q.push_back('{k, v});
	endtask
	// bounded wait; a stuck state ends the run
	task automatic wait_state(input logic [1:0] s, input int lim);
		while (resp_state !== s && lim > 0)
		begin
			@(negedge clk_sys);
			lim--;
		end
		if (resp_state !== s)
		begin
			err_count++;
			$display("mismatch wait expected %h seen %h", s, resp_state);
			close_out();
		end
	endtask
	task automatic pulse(ref logic sig);
		@(negedge clk_sys);
		sig = 1'b1;
		@(negedge clk_sys);
		sig = 1'b0;
	endtask
	// low for one whole cycle, then high again
	task automatic off_on(ref logic sig);
		@(negedge clk_sys);
		sig = 1'b0;
		@(negedge clk_sys);
		sig = 1'b1;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// monitor: compares just after each edge so updates have landed
	initial
	begin : mon
		ovr_note_t r;
		forever
		begin
			@(posedge clk_sys);
			#1;
			while (note_q.size() > 0)
			begin
				r = note_q.pop_front();
				case (r.kind)
					0: check("setting", cfg_rd_data, r.val);
					1: check("flags", {2'h0, alert_n_o, cml_fault, status_byte_ov, status_word_vout,
						status_vout_ov, alert_n_oe}, r.val);
					default: check("state", {4'h0, resp_state, out_enable,
						crowbar_only_action}, r.val);
				endcase
			end
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		rstn = 1'b0;
		run_pin = 1'b1;
		op_on = 1'b1;
		clear_faults = 1'b0;
		reset_cmd = 1'b0;
		other_fault_off = 1'b0;
		alert_mask = 1'b0;
		err_count = 0;
		n_tests = 0;
		void'($urandom(32'h184C8936));
		// range straddles the 120 ms floor so either side of the clamp can be used
		restart_interval_setting = 17'(100 + $urandom % 30);
		iv = (restart_interval_setting < 17'h00078) ? 120 : int'(restart_interval_setting);
		repeat (12) @(negedge clk_sys);
		rstn = 1'b1;
		note(0, 8'hB8);
		note(1, 8'h00);
		// accepted codes, then a refused one
		n = $urandom % 8;
		codes = '{8'h00, 8'h80, 8'h40 | 8'(n), 8'h78 | 8'(n), 8'hB8};
		foreach (codes[i])
		begin
			ovr_host_model_i.wr(codes[i]);
			note(0, codes[i]);
		end
		ovr_host_model_i.wr(8'hC0 | 8'($urandom % 64));
		note(0, 8'hB8);
		note(1, 8'h11);
		pulse(reset_cmd);
		note(1, 8'h00);
		$display("setting writes done");
		// immediate latch-off, then off-then-on release
		ovr_host_model_i.wr(8'h80);
		ovr_host_model_i.ov(1'b1);
		note(2, {ovr_st_latched, 2'b00});
		note(1, 8'h0F);
		ovr_host_model_i.ov(1'b0);
		off_on(op_on);
		off_on(run_pin);
		@(negedge clk_sys);
		note(2, {ovr_st_run, 2'b10});
		note(1, 8'h00);
		$display("latch done");
		// crowbar only, alert masked
		ovr_host_model_i.wr(8'h00);
		alert_mask = 1'b1;
		ovr_host_model_i.ov(1'b1);
		note(2, {ovr_st_run, 2'b11});
		note(1, 8'h0E);
		ovr_host_model_i.ov(1'b0);
		note(2, {ovr_st_run, 2'b10});
		pulse(clear_faults);
		note(1, 8'h00);
		alert_mask = 1'b0;
		$display("crowbar done");
		// delayed latch with random step count
		n = 1 + $urandom % 7;
		ovr_host_model_i.wr(8'h40 | 8'(n));
		ovr_host_model_i.ov(1'b1);
		note(2, {ovr_st_persist, 2'b10});
		repeat (n * 250 - 10) @(negedge clk_sys);
		note(2, {ovr_st_persist, 2'b10});
		wait_state(ovr_st_latched, 30);
		note(2, {ovr_st_latched, 2'b00});
		ovr_host_model_i.ov(1'b0);
		off_on(run_pin);
		$display("delayed latch done");
		// glitch restarts the filter, then delayed retry
		ovr_host_model_i.wr(8'h7A);
		ovr_host_model_i.ov(1'b1);
		repeat (100) @(negedge clk_sys);
		ovr_host_model_i.ov(1'b0);
		note(2, {ovr_st_run, 2'b10});
		ovr_host_model_i.ov(1'b1);
		wait_state(ovr_st_retry, 600);
		note(2, {ovr_st_retry, 2'b00});
		ovr_host_model_i.ov(1'b0);
		pulse(other_fault_off);
		note(2, {ovr_st_latched, 2'b00});
		off_on(run_pin);
		$display("delayed retry done");
		// unlimited retry, interval floor of 120 ms
		ovr_host_model_i.wr(8'hB8);
		ovr_host_model_i.ov(1'b1);
		note(2, {ovr_st_retry, 2'b00});
		note(1, 8'h0F);
		ovr_host_model_i.ov(1'b0);
		// still waiting two cycles before the interval ends, run just after it
		repeat (10 * iv - 3) @(negedge clk_sys);
		note(2, {ovr_st_retry, 2'b00});
		wait_state(ovr_st_run, 8);
		note(2, {ovr_st_run, 2'b10});
		note(1, 8'h0F);
		$display("retry done");
		repeat (3) @(negedge clk_sys);
		close_out();
	end
endmodule
`default_nettype wire
